// ---- spe_regs.svh ----
`ifndef SPE_REGS_SVH
`define SPE_REGS_SVH

// ******************************************************************
// Timing constants
// ******************************************************************
`define SPE_CLK_MHZ      125
`define SPE_WC_MS        5
// Longest time in whole cycles: milliseconds times clock MHz times 1000
`define SPE_WC_CYC       (`SPE_WC_MS * `SPE_CLK_MHZ * 1000)
`define SPE_PU_MS        1
`define SPE_END_SETTLE   3'h4

// ******************************************************************
// Op-codes
// ******************************************************************
`define SPE_OP_WREN      8'h06
`define SPE_OP_WRDI      8'h04
`define SPE_OP_RDSR      8'h05
`define SPE_OP_WRSR      8'h01
`define SPE_OP_READ      8'h03
`define SPE_OP_WRITE     8'h02

// ******************************************************************
// Status byte layout and reset values
// ******************************************************************
`define SPE_SR_PPEN      7
`define SPE_SR_BP1       3
`define SPE_SR_BP0       2
`define SPE_SR_WEL       1
`define SPE_SR_BUSY      0
`define SPE_SR_RST       8'h00

// ******************************************************************
// Array geometry
// ******************************************************************
`define SPE_MEM_BYTES    4096
`define SPE_PAGE_BYTES   32
`define SPE_QTR_BASE     12'hC00
`define SPE_HALF_BASE    12'h800

`endif

// ---- spe_pkg.sv ----
package spe_pkg;

  // ****************************************************************
  // Command engine states
  // ****************************************************************
  typedef enum logic [6:0] {
    ST_OPC  = 7'b0000001,
    ST_AHI  = 7'b0000010,
    ST_ALO  = 7'b0000100,
    ST_DATA = 7'b0001000,
    ST_SR   = 7'b0010000,
    ST_CMD  = 7'b0100000,
    ST_SKIP = 7'b1000000
  } spe_state_t;

  // ****************************************************************
  // Byte passed from the link to the core
  // ****************************************************************
  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } spe_word_t;

endpackage

// ---- spe_buf.sv ----
`timescale 1ns/1ps

module spe_buf #(
  parameter int W     = 9,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  import spe_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  store_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic          push;
  logic          pop;

  // Pointer advance with wrap at the depth
  function automatic logic [PW-1:0] nxt_ptr(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      nxt_ptr = '0;
    end else begin
      nxt_ptr = p + PW'(1);
    end
  endfunction

  // Handshake terms and read side
  assign in_ready_o  = (count_r != CW'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = store_r[rd_ptr_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      store_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= nxt_ptr(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= nxt_ptr(rd_ptr_r);
      end
      if (push && !pop) begin
        count_r <= count_r + CW'(1);
      end else if (pop && !push) begin
        count_r <= count_r - CW'(1);
      end
    end
  end

endmodule

// ---- spe_top.sv ----
`timescale 1ns/1ps
`include "spe_regs.svh"

// Function
// - Serial input is sampled on each rising serial clock edge while selected and hold is high.
// - Serial output bits change on the falling serial clock edge.
// - Output is high impedance whenever chip select is high.
// - Deselected means standby, unless a write cycle is still running.
// - Write-protect pin high never blocks a write.
// - Pin low with protect enable set rejects status writes.
// - Hold low pauses transfer, high resumes, sequence state is kept.
// - Self-timed write cycle runs 5 ms, from the end of the select-high settle after the closing edge.
// - Hardware protection active only for pin low and enable bit set.

module spe_top #(
  parameter int WC_CYCLES = `SPE_WC_CYC
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic sck_i,
  input  wire logic cs_n_i,
  input  wire logic si_i,
  input  wire logic hold_n_i,
  input  wire logic wp_n_i,
  output logic      so_o,
  output logic      so_oe_o,
  output logic      standby_o
);
  import spe_pkg::*;

  localparam logic [7:0] SR_RST = `SPE_SR_RST;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]       mem_r [`SPE_MEM_BYTES];
  logic [7:0]       pbuf_r [`SPE_PAGE_BYTES];

  // Link side
  logic [2:0]       bit_cnt_r;
  logic [6:0]       sh_r;
  logic [1:0]       byte_cnt_r;
  logic [7:0]       lop_r;
  logic             rd_blk_r;
  logic [3:0]       ahi_r;
  logic [11:0]      rd_addr_r;
  logic [7:0]       sr_m_r;
  logic [7:0]       sr_l_r;
  spe_word_t        lnk_word_r;
  logic             lnk_tog_r;
  logic             so_r;
  logic             so_oe_r;
  logic             lnk_off;
  logic             rd_act;
  logic [7:0]       cur_byte;
  logic [7:0]       in_byte;

  // Core side
  logic             cs_m_r;
  logic             cs_s_r;
  logic             wp_m_r;
  logic             wp_s_r;
  logic             tg_m_r;
  logic             tg_s_r;
  logic             tg_d_r;
  spe_word_t        pend_r;
  logic             pend_v_r;
  logic [2:0]       end_cnt_r;
  logic             buf_in_rdy;
  logic             buf_v;
  logic [8:0]       buf_data;
  spe_word_t        buf_w;
  logic             eng_rdy;
  logic             pop;
  logic             done;
  spe_state_t       state_r;
  logic [7:0]       op_r;
  logic [11:0]      wa_r;
  logic [31:0]      mask_r;
  logic [7:0]       sr_new_r;
  logic             frame_r;
  logic             wel_r;
  logic             busy_r;
  logic [1:0]       bp_r;
  logic             ppen_r;
  logic [19:0]      timer_r;
  logic             copying;
  logic             hw_prot;
  logic [7:0]       status;

  // Block protection decode for a page address
  function automatic logic blk_prot(input logic [1:0] bp, input logic [11:0] a);
    case (bp)
      2'h1:    blk_prot = (a >= `SPE_QTR_BASE);
      2'h2:    blk_prot = (a >= `SPE_HALF_BASE);
      2'h3:    blk_prot = 1'b1;
      default: blk_prot = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Link domain, serial clock
  // ****************************************************************

  // Byte being completed on this rising edge
  assign in_byte = {sh_r, si_i};

  // Bit and byte framing; select high clears it whatever the clock idle
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_r  <= 3'h0;
      sh_r       <= 7'h00;
      byte_cnt_r <= 2'h0;
      lop_r      <= 8'h00;
      ahi_r      <= 4'h0;
      rd_addr_r  <= 12'h000;
      rd_blk_r   <= 1'b0;
    end else if (hold_n_i) begin
      sh_r      <= in_byte[6:0];
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        if (byte_cnt_r != 2'h3) begin
          byte_cnt_r <= byte_cnt_r + 2'h1;
        end
        case (byte_cnt_r)
          2'h0: begin
            lop_r    <= in_byte;
            rd_blk_r <= sr_l_r[`SPE_SR_BUSY];
          end
          2'h1:    ahi_r <= in_byte[3:0];
          2'h2:    rd_addr_r <= {ahi_r, in_byte};
          default: rd_addr_r <= rd_addr_r + 12'h001;
        endcase
      end
    end
  end

  // Status mirror into the link domain, two stages
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      sr_m_r <= 8'h00;
      sr_l_r <= 8'h00;
    end else begin
      sr_m_r <= status;
      sr_l_r <= sr_m_r;
    end
  end

  // Completed byte and its toggle; kept across frames for the core
  always_ff @(posedge sck_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lnk_word_r <= '0;
      lnk_tog_r  <= 1'b0;
    end else if (!cs_n_i && hold_n_i && bit_cnt_r == 3'h7) begin
      lnk_word_r <= '{first: (byte_cnt_r == 2'h0), data: in_byte};
      lnk_tog_r  <= ~lnk_tog_r;
    end
  end

  // Read data source; a read opened during a write cycle stays silent
  assign rd_act   = ((lop_r == `SPE_OP_READ) && byte_cnt_r == 2'h3
                     && !rd_blk_r)
                 || ((lop_r == `SPE_OP_RDSR) && byte_cnt_r != 2'h0);
  assign cur_byte = (lop_r == `SPE_OP_RDSR) ? sr_l_r : mem_r[rd_addr_r];
  assign lnk_off  = cs_n_i | ~hold_n_i;

  // Output shifter on the falling edge, tri-stated off frame or in hold
  always_ff @(negedge sck_i or posedge lnk_off) begin
    if (lnk_off) begin
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      so_r    <= cur_byte[~bit_cnt_r];
      so_oe_r <= rd_act;
    end
  end

  assign so_o    = so_r;
  assign so_oe_o = so_oe_r;

  // ****************************************************************
  // Core domain, system clock
  // ****************************************************************

  // Pin and toggle synchronisers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      wp_m_r <= 1'b1;
      wp_s_r <= 1'b1;
      tg_m_r <= 1'b0;
      tg_s_r <= 1'b0;
      tg_d_r <= 1'b0;
    end else begin
      cs_m_r <= cs_n_i;
      cs_s_r <= cs_m_r;
      wp_m_r <= wp_n_i;
      wp_s_r <= wp_m_r;
      tg_m_r <= lnk_tog_r;
      tg_s_r <= tg_m_r;
      tg_d_r <= tg_s_r;
    end
  end

  // Catch a byte on toggle; hold it until the buffer takes it
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pend_r   <= '0;
      pend_v_r <= 1'b0;
    end else if (tg_s_r ^ tg_d_r) begin
      pend_r   <= lnk_word_r;
      pend_v_r <= 1'b1;
    end else if (buf_in_rdy) begin
      pend_v_r <= 1'b0;
    end
  end

  spe_buf #(
    .W     ($bits(spe_word_t)),
    .DEPTH (2)
  ) u_buf (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (pend_v_r),
    .in_ready_o  (buf_in_rdy),
    .in_data_i   (pend_r),
    .out_valid_o (buf_v),
    .out_ready_i (eng_rdy),
    .out_data_o  (buf_data)
  );

  // Engine stalls while the page is being copied into the array
  assign buf_w   = spe_word_t'(buf_data);
  assign copying = busy_r && (timer_r[19:5] == 15'h0000);
  assign eng_rdy = !copying;
  assign pop     = buf_v && eng_rdy;

  // Select-high settle so the last byte is drained before closing
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !cs_s_r) begin
      end_cnt_r <= 3'h0;
    end else if (end_cnt_r != `SPE_END_SETTLE) begin
      end_cnt_r <= end_cnt_r + 3'h1;
    end
  end

  assign done = frame_r && (end_cnt_r == `SPE_END_SETTLE) && !buf_v && !pend_v_r;

  // Frame open flag
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      frame_r <= 1'b0;
    end else if (pop && buf_w.first) begin
      frame_r <= 1'b1;
    end else if (done) begin
      frame_r <= 1'b0;
    end
  end

  // Command sequence; anything during a write cycle is skipped
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_r <= ST_OPC;
      op_r    <= 8'h00;
    end else if (pop && buf_w.first) begin
      op_r <= buf_w.data;
      if (busy_r) begin
        state_r <= ST_SKIP;
      end else begin
        case (buf_w.data)
          `SPE_OP_WREN:  state_r <= ST_CMD;
          `SPE_OP_WRDI:  state_r <= ST_CMD;
          `SPE_OP_WRSR:  state_r <= ST_SR;
          `SPE_OP_WRITE: state_r <= ST_AHI;
          default:       state_r <= ST_SKIP;
        endcase
      end
    end else if (pop) begin
      case (state_r)
        ST_AHI:  state_r <= ST_ALO;
        ST_ALO:  state_r <= ST_DATA;
        ST_SR:   state_r <= ST_CMD;
        ST_CMD:  state_r <= ST_SKIP;
        default: state_r <= state_r;
      endcase
    end else if (done) begin
      state_r <= ST_OPC;
    end
  end

  // Address, page load with roll-over, new status value
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wa_r     <= 12'h000;
      mask_r   <= 32'h00000000;
      sr_new_r <= 8'h00;
    end else if (pop && buf_w.first) begin
      mask_r <= 32'h00000000;
    end else if (pop) begin
      case (state_r)
        ST_AHI:  wa_r[11:8] <= buf_w.data[3:0];
        ST_ALO:  wa_r[7:0] <= buf_w.data;
        ST_DATA: begin
          mask_r[wa_r[4:0]] <= 1'b1;
          wa_r[4:0]         <= wa_r[4:0] + 5'h01;
        end
        ST_SR:   sr_new_r <= buf_w.data;
        default: wa_r <= wa_r;
      endcase
    end
  end

  // Page buffer contents
  always_ff @(posedge clk_i) begin
    if (pop && !buf_w.first && state_r == ST_DATA) begin
      pbuf_r[wa_r[4:0]] <= buf_w.data;
    end
  end

  // Hardware protection from pin and enable bit
  assign hw_prot = !wp_s_r && ppen_r;

  // Status bits and the self-timed write cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wel_r   <= SR_RST[`SPE_SR_WEL];
      busy_r  <= SR_RST[`SPE_SR_BUSY];
      bp_r    <= SR_RST[`SPE_SR_BP1:`SPE_SR_BP0];
      ppen_r  <= SR_RST[`SPE_SR_PPEN];
      timer_r <= 20'h00000;
    end else if (busy_r) begin
      timer_r <= timer_r + 20'h00001;
      if (timer_r == 20'(WC_CYCLES - 1)) begin
        busy_r <= 1'b0;
        wel_r  <= 1'b0;
      end
    end else if (done) begin
      timer_r <= 20'h00000;
      if (op_r == `SPE_OP_WREN && state_r == ST_CMD) begin
        wel_r <= 1'b1;
      end else if (op_r == `SPE_OP_WRDI && state_r == ST_CMD) begin
        wel_r <= 1'b0;
      end else if (op_r == `SPE_OP_WRITE && state_r == ST_DATA && mask_r != 32'h00000000
                   && wel_r && !blk_prot(bp_r, wa_r)) begin
        busy_r <= 1'b1;
      end else if (op_r == `SPE_OP_WRSR && state_r == ST_CMD && wel_r) begin
        if (!hw_prot) begin
          ppen_r <= sr_new_r[`SPE_SR_PPEN];
          bp_r   <= sr_new_r[`SPE_SR_BP1:`SPE_SR_BP0];
          busy_r <= 1'b1;
        end
      end
    end
  end

  // Array update during the first page-size cycles of the write cycle
  always_ff @(posedge clk_i) begin
    if (copying && op_r == `SPE_OP_WRITE && mask_r[timer_r[4:0]]) begin
      mem_r[{wa_r[11:5], timer_r[4:0]}] <= pbuf_r[timer_r[4:0]];
    end
  end

  assign status = {ppen_r, 3'h0, bp_r, wel_r, busy_r};

  // Standby once deselected and no write cycle remains
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      standby_o <= 1'b0;
    end else begin
      standby_o <= cs_s_r && !busy_r && !frame_r;
    end
  end

endmodule

// ---- spe_top_props.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Port checker
// ****************************************************************
module spe_top_props #(
  parameter int WC_CYCLES = 625000
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic standby_o
);
  int unsigned hi_cnt_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Counts core cycles with select held high
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !cs_n_i) begin
      hi_cnt_r <= 32'h0;
    end else if (hi_cnt_r < WC_CYCLES + 64) begin
      hi_cnt_r <= hi_cnt_r + 32'h1;
    end
  end

  // Output pin behaviour
  chk_oe_cs_high: assert property (cs_n_i |-> !so_oe_o)
    else $error("output driven while deselected");
  chk_oe_hold_low: assert property (!hold_n_i |-> !so_oe_o)
    else $error("output driven during hold");
  chk_so_high_phase: assert property ((sck_i && $past(sck_i) && so_oe_o && $past(so_oe_o))
    |-> $stable(so_o))
    else $error("output changed while clock high");
  chk_oe_rise_low: assert property ($rose(so_oe_o) |-> !sck_i)
    else $error("output enabled off the falling edge");

  // Standby behaviour
  chk_standby_sel: assert property ((!cs_n_i) [*6] |-> !standby_o)
    else $error("standby while selected");
  chk_standby_oe: assert property (so_oe_o |-> !standby_o)
    else $error("standby while driving output");
  chk_standby_rise: assert property ($rose(standby_o) |-> $past(cs_n_i, 3))
    else $error("standby entered without deselect");
  chk_standby_wc: assert property (hi_cnt_r == WC_CYCLES + 40 |-> standby_o)
    else $error("write cycle outlasted its limit");

  // Main scenarios
  cov_oe_on: cover property ($rose(so_oe_o));
  cov_standby_off: cover property ($fell(standby_o));
  cov_hold: cover property (!hold_n_i && !cs_n_i);
endmodule

bind spe_top spe_top_props #(.WC_CYCLES(WC_CYCLES)) u_spe_top_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i),
  .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .standby_o(standby_o)
);

// ---- spe_host.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Host serial master model
// ****************************************************************
module spe_host #(
  parameter int PU_NS = 1000
) (
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  output logic      hold_n_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  logic pu_done;

  // Idle lines; power-up wait is scaled down
  // A short select pulse at start gives the link flops a clean clear edge
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b0;
    si_o = 1'b0;
    hold_n_o = 1'b1;
    pu_done = 1'b0;
    #2 cs_n_o = 1'b1;
    #(PU_NS - 2) pu_done = 1'b1;
  end

  // One framed transfer, MSB first, clock still outside frames
  task automatic frame(input bit m3, input int n, input logic [63:0] tx, input int hb,
                       output logic [63:0] rx, output logic oe);
    int i;
    rx = 64'h0;
    wait (pu_done);
    sck_o = m3;
    #21 cs_n_o = 1'b0;
    for (i = 0; i < 8 * n; i++) begin
      #4 sck_o = 1'b0;
      si_o = tx[63 - i];
      // Pause only while the clock is low
      if (i == hb) begin
        hold_n_o = 1'b0;
        #40 hold_n_o = 1'b1;
      end
      #12 sck_o = 1'b1;
      rx = {rx[62:0], so_oe_i ? so_i : 1'bz};
      oe = so_oe_i;
      #16;
    end
    #4 sck_o = m3;
    #12 cs_n_o = 1'b1;
    si_o = ~si_o;
    #64;
  endtask
endmodule

// ---- spe_top_tb_top.sv ----
`timescale 1ns/1ps
`include "spe_regs.svh"

module spe_top_tb_top;
  localparam int WC = 200;
  logic        clk_i, rstn_i, wp_n_i, sck_i, cs_n_i, si_i, hold_n_i;
  logic        so_o, so_oe_o, standby_o, oe;
  logic [63:0] rx;
  int          err_total, checks;

  // ****************************************************************
  // Design, host and clock
  // ****************************************************************
  spe_top #(.WC_CYCLES(WC)) u_spe_top (
    .clk_i(clk_i), .rstn_i(rstn_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i),
    .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .standby_o(standby_o)
  );
  spe_host u_spe_host (
    .sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .hold_n_o(hold_n_i),
    .so_i(so_o), .so_oe_i(so_oe_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic results;
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic op(input logic [63:0] tx, input int n, input bit m3 = 1'b0);
    u_spe_host.frame(m3, n, tx, -1, rx, oe);
  endtask

  task automatic rdsr(input bit m3, output logic [7:0] s);
    u_spe_host.frame(m3, 2, {`SPE_OP_RDSR, 56'h0}, -1, rx, oe);
    s = rx[7:0];
  endtask

  task automatic wsr(input logic [7:0] v);
    op({`SPE_OP_WREN, 56'h0}, 1);
    op({`SPE_OP_WRSR, v, 48'h0}, 2, 1'b1);
  endtask

  task automatic wait_ready;
    logic [7:0] s;
    int k;
    for (k = 0; k < 20; k++) begin
      rdsr(1'b0, s);
      if (s[0] === 1'b0) return;
    end
    err_total++;
    $display("ERROR %0t: write cycle never ended", $time);
    results();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_modes;
    logic [7:0] s;
    cmp({7'h00, so_oe_o}, 8'h00);
    cmp({7'h00, standby_o}, 8'h01);
    op({`SPE_OP_WREN, 56'h0}, 1);
    rdsr(1'b0, s);
    cmp(s, 8'h02);
    cmp({7'h00, oe}, 8'h01);
    op({`SPE_OP_WRDI, 56'h0}, 1, 1'b1);
    rdsr(1'b1, s);
    cmp(s, 8'h00);
  endtask

  task automatic t_protect;
    logic [7:0] s;
    wsr(8'h8C);
    cmp({7'h00, standby_o}, 8'h00);
    wait_ready();
    rdsr(1'b0, s);
    cmp(s, 8'h8C);
    @(negedge clk_i) wp_n_i = 1'b0;
    wsr(8'h00);
    rdsr(1'b0, s);
    cmp(s & 8'hFD, 8'h8C);
    @(negedge clk_i) wp_n_i = 1'b1;
    wsr(8'h00);
    wait_ready();
    rdsr(1'b0, s);
    cmp(s, 8'h00);
    @(negedge clk_i) wp_n_i = 1'b0;
    wsr(8'h04);
    wait_ready();
    rdsr(1'b0, s);
    cmp(s, 8'h04);
  endtask

  task automatic t_write_read;
    logic [7:0] s;
    op({`SPE_OP_WREN, 56'h0}, 1);
    u_spe_host.frame(1'b0, 5, {`SPE_OP_WRITE, 16'h0010, 16'hA53C, 24'h0}, 20, rx, oe);
    rdsr(1'b0, s);
    cmp(s, 8'h07);
    op({`SPE_OP_READ, 16'h0010, 40'h0}, 5);
    cmp({7'h00, oe}, 8'h00);
    repeat (WC + 48) @(negedge clk_i);
    cmp({7'h00, standby_o}, 8'h01);
    rdsr(1'b0, s);
    cmp(s, 8'h04);
    u_spe_host.frame(1'b1, 5, {`SPE_OP_READ, 16'h0010, 40'h0}, 14, rx, oe);
    cmp(rx[15:8], 8'hA5);
    cmp(rx[7:0], 8'h3C);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    err_total = 0;
    checks = 0;
    rstn_i = 1'b1;
    wp_n_i = 1'b1;
    #1 rstn_i = 1'b0;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i) rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_modes();
    t_protect();
    t_write_read();
    results();
  end
endmodule
